//--- rtl/vic_capture_ctl.sv
// Video input capture control: registers, window grab, packing
// Function
// [R1] Software loads window start addresses as multiples of eight.
// [R2] Enable bit low disables capture and holds registers and status reset.
// [R3] Odd-field VBI count seeds odd line counter; hard reset sets 11.
// [R4] Even-field VBI count seeds even line counter; hard reset sets 10.
// [R5] Task enable set: only task-flagged VBI lines count as valid.
// [R6] Protection check set: drop timing codes with bad Hamming nibble.
// [R7] Per-window bit enables capture of active video.
// [R8] Per-window VBI field: none, raw, reserved, sliced.
// [R9] Pitch is field times four pixels; zero means 2048 pixels.
// [R10] Four 4:2:2 pixels pack into one 64-bit memory word.
// [R11] Next-window write picks window zero or one for next grab.
// [R12] Auto mode alternates windows each field from selected one.
// [R13] Software writes next-window with or after setting auto mode.
// [R14] Vsync sets pending flag, records field type and captured flags.
// [R15] Vsync pending and captured flags clear by write or reset.
// [R16] Status bit 1 sets when codec finishes a command.
// [R17] Status bit 2 sets when codec pointer hits host threshold.
// [R18] Status bit 3 sets on end-of-image marker in decompression.
// [R19] Status bit 8 reports previous field: zero odd, one even.
// [R20] Bits 9-11 report active, raw, sliced capture; updated each vsync.
// [R21] Stalled bit shows codec finished its FIFO after transfer stop.
// [R22] Software writes zero to reserved control and status bits.
// [R23] Each pending event raises interrupt only with its enable bit.
// [R24] Writing one to clear bits 0-3 clears matching pending flag.
// [R25] Lines go from window start, each one pitch further on.
`timescale 1ns/1ps
module vic_capture_ctl #(
  parameter int FB_AW = 24
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic [3:0]  reg_be_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic [7:0]  vid_data_i,
  input  wire logic        codec_cmd_done_i,
  input  wire logic        codec_ptr_hit_i,
  input  wire logic        codec_eoi_i,
  input  wire logic        codec_stalled_i,
  output logic             fb_we_o,
  output logic [FB_AW-1:0] fb_addr_o,
  output logic      [63:0] fb_data_o,
  output logic             irq_o
);
  import vic_pkg::*;

  if (FB_AW < 13 || FB_AW > ADR_W) begin : g_chk
    $error("FB_AW must lie between 13 and 24");
  end

  // Byte lane merge shared by the global, enable and window registers
  function automatic logic [31:0] be_merge(input logic [31:0] o,
                                           input logic [31:0] n,
                                           input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      be_merge[8*i +: 8] = be[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  // Line step in bytes from a window control word
  function automatic logic [12:0] pitch_bytes(input logic [11:0] wc);
    logic [8:0] p;
    p = wc[WC_PITCH_LSB +: 9];
    pitch_bytes = (p == 9'h000) ? PITCH_MAX_BYTES : {1'b0, p, 3'h0}; // [R9]
  endfunction

  vic_code_if cd ();

  vic_code_parse u_parse (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .vid_data_i (vid_data_i),
    .cd         (cd)
  );

  logic [31:0]      glb_r, glb_nxt;
  logic [WC_W-1:0]  wctl_r [2];
  logic [WC_W-1:0]  wctl_nxt [2];
  logic [ADR_W-1:0] wadr_r [2];
  logic [ADR_W-1:0] wadr_nxt [2];
  logic [3:0]       ien_r, ien_nxt, pend_r, pend_nxt, clr;
  logic [2:0]       capd_r, capd_nxt;
  logic             fdet_r, fdet_nxt, stall_r, stall_nxt;
  logic             en, vsync_ev;
  logic [1:0]       wr_wctl, wr_wadr;
  logic [31:0]      tmp;
  logic             vprev_r, vprev_nxt, fld_r, fld_nxt;
  logic             grab_r, grab_nxt, cwin_r, cwin_nxt;
  logic             nwin_r, nwin_nxt, auto_r, auto_nxt;
  logic             armed_r, armed_nxt;
  logic             actl_r, actl_nxt, vbil_r, vbil_nxt;
  logic [3:0]       vleft_r, vleft_nxt;
  logic [2:0]       acc_r, acc_nxt, bcnt_r, bcnt_nxt;
  logic [FB_AW-1:0] ladr_r, ladr_nxt, adr_nxt;
  logic [8:0]       col_r, col_nxt;
  logic [63:0]      pack_r, pack_nxt, dat_nxt;
  logic             we_nxt;
  vic_vbi_t         vtype;

  assign en = glb_r[GC_EN];
  assign cd.check_en = glb_r[GC_RP];                   // [R6]
  assign vsync_ev = cd.code_stb && cd.vbl && !vprev_r;
  for (genvar i = 0; i < 2; i++) begin : g_dec
    assign wr_wctl[i] = reg_wr_i && reg_addr_i == (i ? OFS_WIN1_CTL
                                                      : OFS_WIN0_CTL);
    assign wr_wadr[i] = reg_wr_i && reg_addr_i == (i ? OFS_WIN1_ADDR
                                                      : OFS_WIN0_ADDR);
  end
  assign clr = (reg_wr_i && reg_addr_i == OFS_CLEAR && reg_be_i[0])
               ? reg_wdata_i[3:0] : 4'h0;

  // Configuration and status register next values
  always_comb begin
    glb_nxt   = glb_r;
    ien_nxt   = ien_r;
    tmp       = 32'h0;
    pend_nxt  = pend_r & ~clr;                         // [R24]
    capd_nxt  = clr[0] ? 3'h0 : capd_r;                // [R15]
    fdet_nxt  = fdet_r;
    stall_nxt = codec_stalled_i;                       // [R21]
    if (reg_wr_i && reg_addr_i == OFS_GLB_CTL) begin
      // Reserved bits never stored [R22]
      glb_nxt = be_merge(glb_r, reg_wdata_i, reg_be_i) & GC_MASK;
    end
    if (reg_wr_i && reg_addr_i == OFS_IRQ_EN) begin
      tmp     = be_merge({28'h0, ien_r}, reg_wdata_i, reg_be_i);
      ien_nxt = tmp[3:0];
    end
    for (int i = 0; i < 2; i++) begin
      wctl_nxt[i] = wctl_r[i];
      wadr_nxt[i] = wadr_r[i];
      if (wr_wctl[i]) begin
        tmp = be_merge({20'h0, wctl_r[i]}, reg_wdata_i, reg_be_i);
        wctl_nxt[i] = tmp[WC_W-1:0];
      end
      if (wr_wadr[i]) begin
        tmp = be_merge({8'h0, wadr_r[i]}, reg_wdata_i, reg_be_i);
        wadr_nxt[i] = {tmp[ADR_W-1:3], 3'h0};          // [R1]
      end
    end
    // Events set after the clear so a coincident set wins
    if (vsync_ev) begin
      pend_nxt[0] = 1'b1;                              // [R14]
      fdet_nxt    = fld_r;                             // [R19]
      capd_nxt    = acc_r;                             // [R20]
    end
    if (codec_cmd_done_i) pend_nxt[1] = 1'b1;          // [R16]
    if (codec_ptr_hit_i)  pend_nxt[2] = 1'b1;          // [R17]
    if (codec_eoi_i)      pend_nxt[3] = 1'b1;          // [R18]
    if (!en) begin
      // Soft reset holds everything but the global word [R2]
      ien_nxt   = 4'h0;
      pend_nxt  = 4'h0;
      capd_nxt  = 3'h0;
      fdet_nxt  = 1'b0;
      stall_nxt = 1'b0;
      for (int i = 0; i < 2; i++) begin
        wctl_nxt[i] = WC_RST;
        wadr_nxt[i] = '0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      glb_r   <= GC_RST;                               // [R3] [R4]
      ien_r   <= 4'h0;
      pend_r  <= 4'h0;
      capd_r  <= 3'h0;
      fdet_r  <= 1'b0;
      stall_r <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        wctl_r[i] <= WC_RST;
        wadr_r[i] <= '0;
      end
    end else begin
      glb_r   <= glb_nxt;
      ien_r   <= ien_nxt;
      pend_r  <= pend_nxt;
      capd_r  <= capd_nxt;
      fdet_r  <= fdet_nxt;
      stall_r <= stall_nxt;
      wctl_r  <= wctl_nxt;
      wadr_r  <= wadr_nxt;
    end
  end

  assign vtype = vic_vbi_t'(wctl_r[cwin_r][WC_VBI_LSB +: 2]);

  // Window sequencing, line tracking and pixel packing
  always_comb begin
    vprev_nxt = vprev_r;
    fld_nxt   = fld_r;
    grab_nxt  = grab_r;
    cwin_nxt  = cwin_r;
    nwin_nxt  = nwin_r;
    auto_nxt  = auto_r;
    armed_nxt = armed_r;
    actl_nxt  = actl_r;
    vbil_nxt  = vbil_r;
    vleft_nxt = vleft_r;
    acc_nxt   = acc_r;
    ladr_nxt  = ladr_r;
    col_nxt   = col_r;
    pack_nxt  = pack_r;
    bcnt_nxt  = bcnt_r;
    we_nxt    = 1'b0;
    adr_nxt   = fb_addr_o;
    dat_nxt   = fb_data_o;
    if (cd.code_stb) begin
      vprev_nxt = cd.vbl;
      fld_nxt   = cd.fld;
      if (vsync_ev) begin
        acc_nxt   = 3'h0;
        vleft_nxt = cd.fld ? glb_r[GC_EVEN_LSB +: 4]   // [R4]
                           : glb_r[GC_ODD_LSB +: 4];   // [R3]
        grab_nxt  = armed_r;
        cwin_nxt  = nwin_r;
        ladr_nxt  = wadr_r[nwin_r][FB_AW-1:0];         // [R25]
        if (armed_r && auto_r) begin
          nwin_nxt = !nwin_r;                          // [R12]
        end else begin
          armed_nxt = 1'b0;                            // [R12]
        end
      end else if (!cd.hbl) begin
        // Start of line: choose what this line carries
        col_nxt  = 9'h000;
        bcnt_nxt = 3'h0;
        actl_nxt = !cd.vbl && grab_r && wctl_r[cwin_r][WC_CAP]; // [R7]
        vbil_nxt = cd.vbl && grab_r && vleft_r != 4'h0
                   && (!glb_r[GC_TASK] || cd.task_b)   // [R5]
                   && (vtype == VBI_RAW || vtype == VBI_SLICED); // [R8]
        if (cd.vbl && vleft_r != 4'h0) begin
          vleft_nxt = vleft_r - 4'h1;
        end
      end else begin
        if (actl_r) begin
          ladr_nxt = ladr_r
                     + FB_AW'(pitch_bytes(wctl_r[cwin_r])); // [R25] [R9]
        end
        actl_nxt = 1'b0;
        vbil_nxt = 1'b0;
      end
    end
    if (cd.byte_stb && actl_r) begin
      // First byte lands in the low lane of the word [R10]
      pack_nxt = {cd.byte_d, pack_r[63:8]};
      bcnt_nxt = bcnt_r + 3'h1;
      if (bcnt_r == LAST_LANE) begin
        we_nxt     = 1'b1;
        dat_nxt    = pack_nxt;
        adr_nxt    = ladr_r + FB_AW'({col_r, 3'h0});
        col_nxt    = col_r + 9'h001;
        acc_nxt[0] = 1'b1;
      end
    end
    if (cd.byte_stb && vbil_r) begin
      if (vtype == VBI_SLICED) acc_nxt[2] = 1'b1;
      else acc_nxt[1] = 1'b1;
    end
    // Trigger write follows the field-end update and overrides it
    if (reg_wr_i && reg_addr_i == OFS_NEXT_WIN && reg_be_i[0]) begin
      nwin_nxt  = reg_wdata_i[NW_SEL];                 // [R11]
      auto_nxt  = reg_wdata_i[NW_AUTO];                // [R13]
      armed_nxt = 1'b1;
    end
    if (!en) begin
      grab_nxt  = 1'b0;                                // [R2]
      armed_nxt = 1'b0;
      nwin_nxt  = 1'b0;
      auto_nxt  = 1'b0;
      actl_nxt  = 1'b0;
      vbil_nxt  = 1'b0;
      acc_nxt   = 3'h0;
      we_nxt    = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vprev_r   <= 1'b0;
      fld_r     <= 1'b0;
      grab_r    <= 1'b0;
      cwin_r    <= 1'b0;
      nwin_r    <= 1'b0;
      auto_r    <= 1'b0;
      armed_r   <= 1'b0;
      actl_r    <= 1'b0;
      vbil_r    <= 1'b0;
      vleft_r   <= 4'h0;
      acc_r     <= 3'h0;
      ladr_r    <= '0;
      col_r     <= 9'h000;
      pack_r    <= 64'h0;
      bcnt_r    <= 3'h0;
      fb_we_o   <= 1'b0;
      fb_addr_o <= '0;
      fb_data_o <= 64'h0;
    end else begin
      vprev_r   <= vprev_nxt;
      fld_r     <= fld_nxt;
      grab_r    <= grab_nxt;
      cwin_r    <= cwin_nxt;
      nwin_r    <= nwin_nxt;
      auto_r    <= auto_nxt;
      armed_r   <= armed_nxt;
      actl_r    <= actl_nxt;
      vbil_r    <= vbil_nxt;
      vleft_r   <= vleft_nxt;
      acc_r     <= acc_nxt;
      ladr_r    <= ladr_nxt;
      col_r     <= col_nxt;
      pack_r    <= pack_nxt;
      bcnt_r    <= bcnt_nxt;
      fb_we_o   <= we_nxt;
      fb_addr_o <= adr_nxt;
      fb_data_o <= dat_nxt;
    end
  end

  // Read data and interrupt line; write-only words read zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0;
      irq_o       <= 1'b0;
    end else begin
      reg_rdata_o <= (reg_rd_i && reg_addr_i == OFS_STATUS)
                     ? {19'h0, stall_r, capd_r, fdet_r, 4'h0, pend_r}
                     : 32'h0;
      irq_o       <= |(pend_r & ien_r);                // [R23]
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_vsync;
    vsync_ev && en;
  endsequence
  sequence s_line_end;
    cd.code_stb && cd.hbl && !vsync_ev && actl_r && en;
  endsequence

  a_vsync_pend: assert property (s_vsync |=> pend_r[0]) // [R14]
    else $error("vsync did not set pending");
  a_field_rec: assert property (s_vsync |=> fdet_r == $past(fld_r)) // [R19]
    else $error("previous field not recorded");
  a_clear_pend: assert property (clr[0] && !vsync_ev |=> !pend_r[0]
                                 && capd_r == 3'h0) // [R24]
    else $error("vsync pending not cleared");
  a_soft_reset: assert property (!en |=> pend_r == 4'h0 && ien_r == 4'h0
                                 && !fb_we_o) // [R2]
    else $error("soft reset did not hold state");
  a_cmd_pend: assert property (codec_cmd_done_i && en |=> pend_r[1]) // [R16]
    else $error("command done not pending");
  a_irq_gate: assert property ((pend_r & ien_r) == 4'h0 |=> !irq_o) // [R23]
    else $error("interrupt without enabled pending");
  a_pitch_step: assert property (s_line_end |=> ladr_r == $past(ladr_r)
                 + FB_AW'(pitch_bytes($past(wctl_r[cwin_r])))) // [R25]
    else $error("line address did not step one pitch");
  a_auto_alt: assert property (s_vsync ##0 (armed_r && auto_r
                 && !reg_wr_i) |=> nwin_r != $past(nwin_r)) // [R12]
    else $error("auto mode did not alternate");
  a_pack_word: assert property (fb_we_o |-> $past(bcnt_r) == LAST_LANE
                 && fb_addr_o[2:0] == 3'h0) // [R10]
    else $error("word written before eight bytes");
endmodule // vic_capture_ctl

//--- rtl/vic_code_if.sv
// Decoded timing codes and video bytes from parser to control
`timescale 1ns/1ps
interface vic_code_if;
  logic       check_en;
  logic       code_stb;
  logic       fld;
  logic       vbl;
  logic       hbl;
  logic       task_b;
  logic       byte_stb;
  logic [7:0] byte_d;
  modport src (input check_en, output code_stb, fld, vbl, hbl, task_b,
               byte_stb, byte_d);
  modport dst (output check_en, input code_stb, fld, vbl, hbl, task_b,
               byte_stb, byte_d);
endinterface

//--- rtl/vic_code_parse.sv
// Timing code parser for the incoming coded video byte stream
`timescale 1ns/1ps
module vic_code_parse (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] vid_data_i,
  vic_code_if.src         cd
);
  import vic_pkg::*;

  typedef enum logic [1:0] {
    PRE_IDLE = 2'b00,
    PRE_FF   = 2'b01,
    PRE_Z1   = 2'b10,
    PRE_Z2   = 2'b11
  } vic_pre_t;

  // Protection nibble must match the field, blanking bits
  function automatic logic ham_ok(input logic [7:0] xy);
    logic f, v, h;
    f = xy[XY_F];
    v = xy[XY_V];
    h = xy[XY_H];
    ham_ok = xy[3:0] == {v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction

  vic_pre_t   pre_r, pre_nxt;
  logic [7:0] s1_r, s2_r;
  logic       stb_r, stb_nxt, f_r, f_nxt, v_r, v_nxt;
  logic       h_r, h_nxt, t_r, t_nxt, line_r, line_nxt;
  logic       bstb_r, bstb_nxt;
  logic [7:0] byte_r, byte_nxt;

  // Pin bytes pass two flops before anything looks at them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
    end else begin
      s1_r <= vid_data_i;
      s2_r <= s1_r;
    end
  end

  // Preamble tracking and code decode
  always_comb begin
    pre_nxt  = PRE_IDLE;
    stb_nxt  = 1'b0;
    f_nxt    = f_r;
    v_nxt    = v_r;
    h_nxt    = h_r;
    t_nxt    = t_r;
    line_nxt = line_r;
    bstb_nxt = 1'b0;
    byte_nxt = byte_r;
    unique case (pre_r)
      PRE_IDLE: begin
        if (s2_r == 8'hff) begin
          pre_nxt = PRE_FF;
        end else if (line_r && s2_r != 8'h00) begin
          // Reserved values never carry video, so no lookahead needed
          bstb_nxt = 1'b1;
          byte_nxt = s2_r;
        end
      end
      PRE_FF: begin
        if (s2_r == 8'h00) begin
          pre_nxt = PRE_Z1;
        end else if (s2_r == 8'hff) begin
          pre_nxt = PRE_FF;
        end
      end
      PRE_Z1: begin
        if (s2_r == 8'h00) begin
          pre_nxt = PRE_Z2;
        end else if (s2_r == 8'hff) begin
          pre_nxt = PRE_FF;
        end
      end
      PRE_Z2: begin
        // Bad codes are dropped only when checking is on [R6]
        if (!cd.check_en || ham_ok(s2_r)) begin
          stb_nxt  = 1'b1;
          f_nxt    = s2_r[XY_F];
          v_nxt    = s2_r[XY_V];
          h_nxt    = s2_r[XY_H];
          t_nxt    = s2_r[XY_TASK];
          line_nxt = !s2_r[XY_H];
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_r  <= PRE_IDLE;
      stb_r  <= 1'b0;
      f_r    <= 1'b0;
      v_r    <= 1'b0;
      h_r    <= 1'b1;
      t_r    <= 1'b0;
      line_r <= 1'b0;
      bstb_r <= 1'b0;
      byte_r <= 8'h00;
    end else begin
      pre_r  <= pre_nxt;
      stb_r  <= stb_nxt;
      f_r    <= f_nxt;
      v_r    <= v_nxt;
      h_r    <= h_nxt;
      t_r    <= t_nxt;
      line_r <= line_nxt;
      bstb_r <= bstb_nxt;
      byte_r <= byte_nxt;
    end
  end

  assign cd.code_stb = stb_r;
  assign cd.fld      = f_r;
  assign cd.vbl      = v_r;
  assign cd.hbl      = h_r;
  assign cd.task_b   = t_r;
  assign cd.byte_stb = bstb_r;
  assign cd.byte_d   = byte_r;
endmodule // vic_code_parse

//--- rtl/vic_pkg.sv
// Shared constants for the video input capture control block
package vic_pkg;
  // Register byte offsets
  localparam logic [15:0] OFS_WIN0_CTL  = 16'h3e00;
  localparam logic [15:0] OFS_WIN1_CTL  = 16'h3e04;
  localparam logic [15:0] OFS_WIN0_ADDR = 16'h3e10;
  localparam logic [15:0] OFS_WIN1_ADDR = 16'h3e14;
  localparam logic [15:0] OFS_GLB_CTL   = 16'h3e1c;
  localparam logic [15:0] OFS_NEXT_WIN  = 16'h3e20;
  localparam logic [15:0] OFS_STATUS    = 16'h3e30;
  localparam logic [15:0] OFS_CLEAR     = 16'h3e34;
  localparam logic [15:0] OFS_IRQ_EN    = 16'h3e38;
  // Global control fields
  localparam int GC_EN       = 0;
  localparam int GC_ODD_LSB  = 8;
  localparam int GC_EVEN_LSB = 12;
  localparam int GC_TASK     = 16;
  localparam int GC_RP       = 24;
  localparam logic [31:0] GC_RST  = 32'h0101_ab00;
  localparam logic [31:0] GC_MASK = 32'h0101_ff01;
  // Window control fields
  localparam int WC_CAP       = 0;
  localparam int WC_VBI_LSB   = 1;
  localparam int WC_PITCH_LSB = 3;
  localparam int WC_W         = 12;
  localparam logic [11:0] WC_RST = 12'h000;
  localparam int ADR_W = 24;
  // Next window trigger fields
  localparam int NW_SEL  = 0;
  localparam int NW_AUTO = 1;
  // Status fields
  localparam int ST_FIELD = 8;
  localparam int ST_ACT   = 9;
  localparam int ST_STALL = 12;
  // Pitch: units of four pixels, two bytes a pixel, zero means 2048 px
  localparam int PITCH_MAX_PIX = 2048;
  localparam int BYTES_PER_PIX = 2;
  localparam logic [12:0] PITCH_MAX_BYTES =
    13'(PITCH_MAX_PIX * BYTES_PER_PIX);
  localparam logic [2:0] LAST_LANE = 3'h7;
  // Timing code byte fields
  localparam int XY_TASK = 7;
  localparam int XY_F    = 6;
  localparam int XY_V    = 5;
  localparam int XY_H    = 4;
  typedef enum logic [1:0] {
    VBI_NONE   = 2'b00,
    VBI_RAW    = 2'b01,
    VBI_RSVD   = 2'b10,
    VBI_SLICED = 2'b11
  } vic_vbi_t;
endpackage

//--- sim/tb.sv
// Self-checking bench for the video input capture control block
`timescale 1ns/1ps
module tb;
  import vic_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [15:0] reg_addr_i = 16'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic [3:0]  reg_be_i = 4'hf;
  logic        reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [7:0]  vid_data_i;
  logic [3:0]  cev = 4'h0;
  logic        fb_we_o;
  logic [23:0] fb_addr_o;
  logic [63:0] fb_data_o;
  logic        irq_o;
  logic [23:0] wa[$];
  logic [63:0] wd[$];
  logic        s;
  int          fails = 0;
  int          checks = 0;
  always #4 clk_i = ~clk_i;
  vic_dec_model i_dec (.clk_i(clk_i), .vid_data_o(vid_data_i));
  vic_capture_ctl i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_be_i(reg_be_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .vid_data_i(vid_data_i), .codec_cmd_done_i(cev[1]),
    .codec_ptr_hit_i(cev[2]), .codec_eoi_i(cev[0]),
    .codec_stalled_i(cev[3]), .fb_we_o(fb_we_o), .fb_addr_o(fb_addr_o),
    .fb_data_o(fb_data_o), .irq_o(irq_o));
  // Collect every frame buffer word write, away from its launch edge
  always @(negedge clk_i) begin
    if (fb_we_o === 1'b1) begin
      wa.push_back(fb_addr_o);
      wd.push_back(fb_data_o);
    end
  end
  task automatic chk(input string n, input logic [63:0] e, s);
    checks++;
    if (s !== e)
      fails++;
    if (s !== e)
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e, m);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk("read data", e, reg_rdata_o & m);
  endtask
  // Status read, masked where a bit is not meant to be judged
  task automatic st(input logic [31:0] e, input logic [31:0] m);
    rd(OFS_STATUS, e, m);
  endtask
  // Send a field and count the words it wrote
  task automatic fld(input logic f, input int n, bad, cnt, nv = 0,
                     input logic vt = 1'b1);
    wa.delete();
    wd.delete();
    i_dec.field(f, n, bad, nv, vt);
    chk("fb count", cnt, wa.size());
  endtask
  task automatic fbw(input logic [23:0] a);
    chk("fb addr", a, wa.pop_front());
    chk("fb data", i_dec.words.pop_front(), wd.pop_front());
  endtask
  task automatic pulse(input int i);
    @(negedge clk_i);
    cev[i] = 1'b1;
    @(negedge clk_i);
    cev[i] = 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog sized well past the whole sequence
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    st(32'h0, 32'hffff_ffff);
    rd(16'h3e08, 32'h0, 32'hffff_ffff);
    rd(OFS_WIN0_CTL, 32'h0, 32'hffff_ffff);
    $display("test reset done");
    // Enable, then program window 0: capture, pitch 8 units
    wr(OFS_GLB_CTL, 32'h0101_ab01);
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_WIN0_CTL, 32'h0000_0043);
    wr(OFS_WIN0_ADDR, 32'h1000);
    wr(OFS_NEXT_WIN, 32'h0);
    fld(1'b0, 2, 0, 4, 1);
    fbw(24'h1000);
    fbw(24'h1008);
    fbw(24'h1040);
    fbw(24'h1048);
    st(32'h1, 32'hffff_ffff);
    chk("irq", 1, irq_o);
    wr(OFS_CLEAR, 32'h1);
    st(32'h0, 32'hffff_ffff);
    chk("irq", 0, irq_o);
    $display("test capture done");
    // Manual trigger grabs one field only
    fld(1'b1, 1, 0, 0);
    st(32'h601, 32'hffff_feff);
    fld(1'b1, 0, 0, 0);
    st(32'h101, 32'hffff_ffff);
    wr(OFS_CLEAR, 32'h0);
    st(32'h101, 32'hffff_ffff);
    // Clear without its byte lane does nothing
    reg_be_i = 4'he;
    wr(OFS_CLEAR, 32'h1);
    reg_be_i = 4'hf;
    st(32'h101, 32'hffff_ffff);
    wr(OFS_CLEAR, 32'hf);
    $display("test status done");
    // Auto alternation from window 1, zero pitch means 2048 pixels
    wr(OFS_WIN1_CTL, 32'h7);
    wr(OFS_WIN1_ADDR, 32'h2000);
    wr(OFS_NEXT_WIN, 32'h3);
    fld(1'b0, 2, 0, 4, 1);
    fbw(24'h2000);
    fbw(24'h2008);
    fbw(24'h3000);
    fbw(24'h3008);
    fld(1'b0, 1, 0, 2);
    fbw(24'h1000);
    fbw(24'h1008);
    st(32'ha01, 32'hffff_ffff);
    // Blanking line without task bit is dropped while filter is on
    fld(1'b1, 0, 0, 0, 1, 1'b0);
    $display("test auto done");
    // Bad protection code dropped only while the check is on
    wr(OFS_CLEAR, 32'hf);
    fld(1'b0, 0, 1, 0);
    st(32'h0, 32'h1);
    // Check, task filter and even-field count all off from here
    wr(OFS_GLB_CTL, 32'h0000_0b01);
    fld(1'b0, 0, 1, 0, 1, 1'b0);
    st(32'h1, 32'he01);
    wr(OFS_CLEAR, 32'hf);
    fld(1'b1, 0, 0, 0, 1);
    st(32'h401, 32'he01);
    fld(1'b0, 0, 0, 0);
    st(32'h1, 32'he01);
    wr(OFS_CLEAR, 32'hf);
    $display("test protection done");
    // Codec events: pending always, interrupt only when enabled
    for (int i = 1; i < 4; i++) begin
      s = i_dec.rnd() % 2;
      cev[3] = s;
      pulse(i % 3);
      st(32'(1 << i) | {19'h0, s, 12'h0}, 32'hffff_ffff);
      chk("irq", 0, irq_o);
      wr(OFS_IRQ_EN, 32'(1 << i));
      st(32'(1 << i) | {19'h0, s, 12'h0}, 32'hffff_ffff);
      chk("irq", 1, irq_o);
      wr(OFS_CLEAR, 32'(1 << i));
      st({19'h0, s, 12'h0}, 32'hffff_ffff);
    end
    cev[3] = 1'b0;
    $display("test codec done");
    // Soft reset clears status and window setup
    pulse(1);
    wr(OFS_GLB_CTL, 32'h0);
    st(32'h0, 32'hffff_ffff);
    wr(OFS_WIN0_CTL, 32'h41);
    wr(OFS_GLB_CTL, 32'h0101_ab01);
    wr(OFS_NEXT_WIN, 32'h0);
    fld(1'b0, 1, 0, 0);
    $display("test soft reset done");
    stop_test();
  end
endmodule // tb

//--- sim/vic_dec_model.sv
// Behavioural video decoder driving a coded 4:2:2 byte stream
`timescale 1ns/1ps
module vic_dec_model (
  input  wire logic       clk_i,
  output logic      [7:0] vid_data_o
);
  logic [31:0] seed = 32'h36;
  logic [63:0] words[$];
  // Blanking filler from time zero, so the pin is never unknown
  initial vid_data_o = 8'h10;
  // Xorshift source shared with the bench, fixed seed
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // One byte a clock, changed off the sampling edge
  task automatic put(input logic [7:0] b);
    @(negedge clk_i);
    vid_data_o = b;
  endtask
  // Timing code; bad flips one protection bit
  task automatic code(input logic f, v, h, bad, t = 1'b1);
    logic [3:0] p;
    p = {v ^ h, f ^ h, f ^ v, f ^ v ^ h ^ bad};
    put(8'hff);
    put(8'h00);
    put(8'h00);
    put({t, f, v, h, p});
  endtask
  // Vsync, nv blanking lines with task bit vt, then n active lines
  task automatic field(input logic f, input int n, input logic bad,
                       input int nv, input logic vt);
    logic [63:0] w;
    logic [7:0]  b;
    words.delete();
    code(f, 1'b0, 1'b1, 1'b0);
    code(f, 1'b1, 1'b1, bad);
    // Blanking lines only raise flags, never reach the frame buffer
    for (int l = 0; l < nv; l++) begin
      code(f, 1'b1, 1'b0, 1'b0, vt);
      repeat (8) put(8'h01 + 8'(rnd() % 32'd254));
      code(f, 1'b1, 1'b1, 1'b0, vt);
    end
    for (int l = 0; l < n; l++) begin
      code(f, 1'b0, 1'b0, 1'b0);
      for (int i = 0; i < 16; i++) begin
        b = 8'h01 + 8'(rnd() % 32'd254); // 00 and ff are never data
        w = {b, w[63:8]};
        put(b);
        if (i % 8 == 7)
          words.push_back(w);
      end
      code(f, 1'b0, 1'b1, 1'b0);
    end
    // Filler alternates so a stale byte never looks held
    repeat (8) begin
      put(8'h80);
      put(8'h10);
    end
  endtask
endmodule // vic_dec_model
